//--- shared/serial_dac_pkg.sv
// Purpose: Shared constants and types of the serial converter link
// Assumes: System clock of 200 MHz on both ends
// Notes:   Times are in picoseconds; cycle counts derive from them
package serial_dac_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS  = 16;
  localparam int DATA_BITS   = 12;
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int CNT_W       = 5;

  localparam logic [DATA_BITS-1:0] DAC_RESET = 12'h000;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PD_1K  = 2'h1,
    MODE_PD_100K = 2'h2,
    MODE_PD_HIZ = 2'h3
  } mode_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int SYNC_HIGH_MIN_PS = 33000;
  localparam int SYNC_HIGH_CYCLES =
    (SYNC_HIGH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_MAX_KHZ       = 30000;
  localparam int SCLK_MIN_PERIOD_PS = (1000000000 + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
  localparam int SCLK_HALF_CYCLES =
    ((SCLK_MIN_PERIOD_PS + 1) / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_5V_PS  = 2500000;
  localparam int WAKE_3V_PS  = 5000000;
  localparam int WAKE_CYCLES = (WAKE_5V_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_W      = 13;

endpackage

//--- shared/dac_link_if.sv
// Purpose: Three-wire write link between host and converter
// Assumes: Host drives all three wires
// Notes:   No two-way pins on this link
`timescale 1ns/1ps
interface dac_link_if;
  logic syncN;
  logic sclk;
  logic din;

  modport host (
    output syncN,
    output sclk,
    output din
  );

  modport device (
    input syncN,
    input sclk,
    input din
  );
endinterface

//--- core/dac_device_end.sv
// Purpose: Converter end: frame capture, converter register, mode control
// Assumes: Link logic clocked by the serial clock; core logic by clk_sys
// Notes:   Frame sync high clears the frame logic without any clock edge
`timescale 1ns/1ps

// Notes on behaviour
// - Frame starts on frame sync falling
// - Shift data on each falling clock edge
// - Sixteenth falling edge executes the frame
// - Host holds sync high at least 33 ns between frames
// - Host may idle sync low between frames
// - Two spare, two mode, twelve data bits
// - Early sync rise discards the frame
// - Reset clears converter register to zero
// - Mode bits pick normal or three terminations
// - Power-down switches termination, stops analog blocks
// - Power-down keeps converter register contents
// - Output valid after wake delay; a normal frame arriving inside the delay sets outValid at once
// - Data is straight unsigned binary code
// - Host sends most significant bit first
// - Byte hosts keep sync low across bytes
// - Host clock idles low, falling-edge stable
// - DSP port: internal clock, 16-bit words
// - Serial clock at most 30 MHz
module dac_device_end #(
  parameter int WakeCycles = serial_dac_pkg::WAKE_CYCLES
) (
  // System clock and reset
  input  wire logic                                 clk_sys,
  input  wire logic                                 rstn,
  // Serial link
  dac_link_if.device                                link,
  // Converter core
  output logic [serial_dac_pkg::DATA_BITS-1:0]      dacCode,
  output serial_dac_pkg::mode_t                     opMode,
  output logic                                      loadPulse,
  // Output stage
  output logic                                      ampConnect,
  output logic                                      tie1k,
  output logic                                      tie100k,
  output logic                                      analogOn,
  output logic                                      outValid
);

  // ****************************************
  // Link domain: frame capture
  // ****************************************
  logic [serial_dac_pkg::CNT_W-1:0]      bitCnt_q = '0;
  logic [serial_dac_pkg::FRAME_BITS-2:0] shift_q = '0;
  logic [serial_dac_pkg::FRAME_BITS-1:0] word_q = 16'h0000;
  logic                                  doneTgl_q = 1'b0;
  logic                                  lastEdge;
  logic                                  frameOpen;

  // Edge count and shifting, cleared while sync is high
  assign frameOpen = (bitCnt_q != serial_dac_pkg::CNT_W'(serial_dac_pkg::FRAME_BITS));
  assign lastEdge  = (bitCnt_q == serial_dac_pkg::CNT_W'(serial_dac_pkg::FRAME_BITS - 1));

  always_ff @(negedge link.sclk or posedge link.syncN) begin
    if (link.syncN) begin
      bitCnt_q <= '0;
      shift_q  <= '0;
    end else if (frameOpen) begin
      bitCnt_q <= bitCnt_q + serial_dac_pkg::CNT_W'(1);
      shift_q  <= {shift_q[serial_dac_pkg::FRAME_BITS-3:0], link.din};
    end
  end

  // Frame word and completion toggle, only on the final edge
  always_ff @(negedge link.sclk) begin
    if (!link.syncN && lastEdge) begin
      word_q    <= {shift_q, link.din};
      doneTgl_q <= ~doneTgl_q;
    end
  end

  // ****************************************
  // Crossing to the system clock
  // ****************************************
  logic tglMeta_q;
  logic tglSync_q;
  logic tglPrev_q;
  logic frameEvt;

  // Chain tracks the toggle in reset, so release shows no stale event
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tglMeta_q <= doneTgl_q;
      tglSync_q <= tglMeta_q;
      tglPrev_q <= tglSync_q;
    end else begin
      tglMeta_q <= doneTgl_q;
      tglSync_q <= tglMeta_q;
      tglPrev_q <= tglSync_q;
    end
  end

  assign frameEvt = tglSync_q ^ tglPrev_q;

  // ****************************************
  // Frame decode
  // ****************************************
  serial_dac_pkg::mode_t                  newMode;
  logic [serial_dac_pkg::DATA_BITS-1:0]   newCode;

  // Bits 15 and 14 are not used
  assign newMode = serial_dac_pkg::mode_t'({word_q[serial_dac_pkg::MODE_HI_POS],
                                            word_q[serial_dac_pkg::MODE_LO_POS]});
  assign newCode = word_q[serial_dac_pkg::DATA_BITS-1:0];

  // ****************************************
  // Converter register and mode
  // ****************************************
  logic [serial_dac_pkg::DATA_BITS-1:0] dacCode_q;
  serial_dac_pkg::mode_t                mode_q;
  logic                                 load_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dacCode_q <= serial_dac_pkg::DAC_RESET;
    end else if (frameEvt && newMode == serial_dac_pkg::MODE_NORMAL) begin
      dacCode_q <= newCode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_q <= serial_dac_pkg::MODE_NORMAL;
    end else if (frameEvt) begin
      mode_q <= newMode;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      load_q <= 1'b0;
    end else begin
      load_q <= frameEvt;
    end
  end

  // ****************************************
  // Wake-up timer
  // ****************************************
  logic [serial_dac_pkg::WAKE_W-1:0] wakeCnt_q;
  logic                              waking;

  assign waking = frameEvt && newMode == serial_dac_pkg::MODE_NORMAL
                  && mode_q != serial_dac_pkg::MODE_NORMAL;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wakeCnt_q <= '0;
    end else if (waking) begin
      wakeCnt_q <= serial_dac_pkg::WAKE_W'(WakeCycles);
    end else if (frameEvt && newMode != serial_dac_pkg::MODE_NORMAL) begin
      wakeCnt_q <= '0;
    end else if (wakeCnt_q != '0) begin
      wakeCnt_q <= wakeCnt_q - serial_dac_pkg::WAKE_W'(1);
    end
  end

  // ****************************************
  // Output stage controls
  // ****************************************
  logic ampConnect_q;
  logic tie1k_q;
  logic tie100k_q;
  logic outValid_q;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ampConnect_q <= 1'b1;
      tie1k_q      <= 1'b0;
      tie100k_q    <= 1'b0;
    end else if (frameEvt) begin
      ampConnect_q <= (newMode == serial_dac_pkg::MODE_NORMAL);
      tie1k_q      <= (newMode == serial_dac_pkg::MODE_PD_1K);
      tie100k_q    <= (newMode == serial_dac_pkg::MODE_PD_100K);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      outValid_q <= 1'b1;
    end else if (frameEvt) begin
      outValid_q <= (newMode == serial_dac_pkg::MODE_NORMAL) && !waking;
    end else if (mode_q == serial_dac_pkg::MODE_NORMAL
                 && wakeCnt_q == serial_dac_pkg::WAKE_W'(1)) begin
      outValid_q <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dacCode    = dacCode_q;
  assign opMode     = mode_q;
  assign loadPulse  = load_q;
  assign ampConnect = ampConnect_q;
  assign tie1k      = tie1k_q;
  assign tie100k    = tie100k_q;
  assign analogOn   = ampConnect_q;
  assign outValid   = outValid_q;

endmodule

//--- core/dac_host_end.sv
// Purpose: Host end: sends one 16-bit write frame per request
// Assumes: clk_sys at 200 MHz; serial clock made by division
// Notes:   Sync idles low after a frame and rises before the next
`timescale 1ns/1ps
module dac_host_end #(
  parameter int SclkHalf = serial_dac_pkg::SCLK_HALF_CYCLES,
  parameter int SyncHigh = serial_dac_pkg::SYNC_HIGH_CYCLES
) (
  // System clock and reset
  input  wire logic                                  clk_sys,
  input  wire logic                                  rstn,
  // Request
  input  wire logic                                  reqValid,
  input  wire logic [serial_dac_pkg::FRAME_BITS-1:0] reqWord,
  output logic                                       reqReady,
  output logic                                       donePulse,
  // Serial link
  dac_link_if.host                                   link
);

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_HIGH  = 2'h1,
    ST_SHIFT = 2'h3
  } state_t;

  state_t                                 state_q;
  logic [7:0]                             cnt_q;
  logic [serial_dac_pkg::CNT_W-1:0]       bitIdx_q;
  logic [serial_dac_pkg::FRAME_BITS-1:0]  shift_q;
  logic                                   syncN_q;
  logic                                   sclk_q;
  logic                                   din_q;
  logic                                   done_q;
  logic                                   highEnd;
  logic                                   halfEnd;
  logic                                   lastFall;

  assign highEnd  = state_q == ST_HIGH && cnt_q == 8'(SyncHigh - 1);
  assign halfEnd  = state_q == ST_SHIFT && cnt_q == 8'(SclkHalf - 1);
  assign lastFall = halfEnd && sclk_q
                    && bitIdx_q == serial_dac_pkg::CNT_W'(serial_dac_pkg::FRAME_BITS - 1);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  if (reqValid) state_q <= ST_HIGH;
        ST_HIGH:  if (highEnd) state_q <= ST_SHIFT;
        ST_SHIFT: if (lastFall) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || state_q == ST_IDLE || highEnd || halfEnd) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 8'(1);
    end
  end

  // ****************************************
  // Link drive
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      syncN_q <= 1'b1;
    end else if (state_q == ST_IDLE && reqValid) begin
      syncN_q <= 1'b1;
    end else if (highEnd) begin
      syncN_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
    end else if (halfEnd) begin
      sclk_q <= ~sclk_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      shift_q <= '0;
      din_q   <= 1'b0;
    end else if (state_q == ST_IDLE && reqValid) begin
      shift_q <= reqWord;
    end else if (halfEnd && !sclk_q) begin
      din_q   <= shift_q[serial_dac_pkg::FRAME_BITS-1];
      shift_q <= {shift_q[serial_dac_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn || state_q == ST_HIGH) begin
      bitIdx_q <= '0;
    end else if (halfEnd && sclk_q) begin
      bitIdx_q <= bitIdx_q + serial_dac_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= lastFall;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reqReady   = state_q == ST_IDLE;
  assign donePulse  = done_q;
  assign link.syncN = syncN_q;
  assign link.sclk  = sclk_q;
  assign link.din   = din_q;

endmodule

//--- verif/dac_link_props.sv
// Purpose: Wire checks on the host-to-converter link
// Assumes: Host makes the serial clock from clk_sys, 4 cycles a half period
// Notes:   Sees only the link wires and the system clock domain
`timescale 1ns/1ps
module dac_link_props (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Link wires
  input wire logic syncN,
  input wire logic sclk,
  input wire logic din
);
  // *****
  // Falling edges in one sync low period
  // *****
  logic [4:0] fallCnt_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn || syncN) begin
      fallCnt_q <= 5'h00;
    end else if ($fell(sclk)) begin
      fallCnt_q <= fallCnt_q + 5'h01;
    end
  end

  // *****
  // Properties
  // *****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_sync_high_gap: assert property ($rose(syncN) |-> syncN [*7])
    else $error("frame sync high gap too short");
  a_idle_clk_low: assert property (syncN |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_data_at_fall: assert property ($fell(sclk) |-> $stable(din))
    else $error("serial data moved at a falling clock edge");
  a_clk_high_len: assert property ($rose(sclk) |-> sclk [*4])
    else $error("serial clock high phase too short");
  a_clk_low_len: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("serial clock low phase too short");
  a_frame_lead: assert property ($fell(syncN) |-> !sclk [*3] ##[1:3] sclk)
    else $error("frame start lead wrong");
  a_sync_rise_done: assert property ($rose(syncN) |-> fallCnt_q == 5'h10)
    else $error("frame sync rose before sixteen edges");
  a_falls_capped: assert property (fallCnt_q <= 5'h10)
    else $error("more than sixteen edges in one frame");
endmodule

//--- verif/serial_dac_input_control_tb.sv
// Purpose: Host and converter ends joined, plus a converter on a bench-driven link
// Assumes: WakeCycles set to 8 on both converters
// Notes:   The second link aborts a frame and overruns one on purpose
`timescale 1ns/1ps
module serial_dac_input_control_tb;
  logic        clk_sys  = 1'b0;
  logic        rstn     = 1'b0;
  logic        reqValid = 1'b0;
  logic [15:0] reqWord  = 16'h0000;
  logic        reqReady, donePulse, loadPulse, loadB;
  logic        ampConnect, tie1k, tie100k, analogOn, outValid;
  logic [11:0] dacCode, codeB;
  logic [15:0] wireWord = 16'h0000;
  int          fails, cmp_count, loadsA, loadsB;
  serial_dac_pkg::mode_t opMode;
  logic [15:0] words [6] = '{16'hCA5C, 16'h1123, 16'h2123, 16'h3FFF, 16'h0FFF, 16'h4000};

  always #2.5 clk_sys = ~clk_sys;

  // *****
  // Ends under test
  // *****
  dac_link_if lnk ();
  dac_link_if lnkB ();
  dac_host_end u_dac_host_end (.clk_sys(clk_sys), .rstn(rstn), .reqValid(reqValid),
    .reqWord(reqWord), .reqReady(reqReady), .donePulse(donePulse), .link(lnk));
  dac_device_end #(.WakeCycles(8)) u_dac_device_end (.clk_sys(clk_sys), .rstn(rstn),
    .link(lnk), .dacCode(dacCode), .opMode(opMode), .loadPulse(loadPulse),
    .ampConnect(ampConnect), .tie1k(tie1k), .tie100k(tie100k), .analogOn(analogOn),
    .outValid(outValid));
  dac_device_end #(.WakeCycles(8)) u_dac_device_end_b (.clk_sys(clk_sys), .rstn(rstn),
    .link(lnkB), .dacCode(codeB), .opMode(), .loadPulse(loadB), .ampConnect(),
    .tie1k(), .tie100k(), .analogOn(), .outValid());
  dac_link_props u_dac_link_props (.clk_sys(clk_sys), .rstn(rstn), .syncN(lnk.syncN),
    .sclk(lnk.sclk), .din(lnk.din));

  always @(negedge lnk.sclk) begin
    if (lnk.syncN === 1'b0) begin
      wireWord <= {wireWord[14:0], lnk.din};
    end
  end
  always @(posedge clk_sys) begin
    if (loadPulse === 1'b1) begin
      loadsA++;
    end
    if (loadB === 1'b1) begin
      loadsB++;
    end
  end

  // *****
  // Tasks
  // *****
  task automatic complete_run();
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkFlag(input logic got, input logic exp);
    chkWord({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic waitHigh(input int sel, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? donePulse : (sel == 1 ? loadPulse : outValid)) !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > lim) begin
        fails++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
      end
    end
  endtask

  task automatic send(input logic [15:0] w);
    reqWord  = w;
    reqValid = 1'b1;
    @(negedge clk_sys);
    reqValid = 1'b0;
    chkFlag(reqReady, 1'b0);
    waitHigh(0, 200);
    waitHigh(1, 10);
  endtask

  // Bench link: data changes on rise, 15 ns clock only inside the frame
  task automatic frameB(input logic [15:0] w, input int falls);
    lnkB.syncN = 1'b0;
    #21;
    for (int i = 0; i < falls; i++) begin
      lnkB.sclk = 1'b1;
      lnkB.din  = w[15 - (i % 16)];
      #7.5;
      lnkB.sclk = 1'b0;
      #7.5;
    end
    lnkB.din   = ~lnkB.din;
    lnkB.syncN = 1'b1;
    #40;
    @(negedge clk_sys);
  endtask

  // *****
  // Sequence
  // *****
  initial begin
    logic [11:0] expCode;
    logic [1:0]  m;
    logic [1:0]  prevM;
    expCode    = 12'h000;
    prevM      = 2'h0;
    lnkB.syncN = 1'b1;
    lnkB.sclk  = 1'b0;
    lnkB.din   = 1'b0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    chkWord({4'h0, dacCode}, 16'h0000);
    chkWord({14'h0000, opMode}, 16'h0000);
    chkFlag(outValid, 1'b1);
    foreach (words[i]) begin
      m = words[i][13:12];
      send(words[i]);
      @(negedge clk_sys);
      if (m == 2'h0) begin
        expCode = words[i][11:0];
      end
      chkWord(wireWord, words[i]);
      chkFlag(lnk.syncN, 1'b0);
      chkWord({4'h0, dacCode}, {4'h0, expCode});
      chkWord({14'h0000, opMode}, {14'h0000, m});
      chkFlag(ampConnect, m == 2'h0);
      chkFlag(analogOn, m == 2'h0);
      chkFlag(tie1k, m == 2'h1);
      chkFlag(tie100k, m == 2'h2);
      chkFlag(outValid, (m == 2'h0) && (prevM == 2'h0));
      if (m == 2'h0 && prevM != 2'h0) begin
        repeat (5) @(negedge clk_sys);
        chkFlag(outValid, 1'b0);
      end
      if (m == 2'h0) begin
        waitHigh(2, 12);
      end
      prevM = m;
    end
    chkWord(loadsA[15:0], 16'h0006);
    frameB(16'h0ABC, 10);
    chkWord({4'h0, codeB}, 16'h0000);
    chkWord(loadsB[15:0], 16'h0000);
    frameB(16'h0123, 20);
    chkWord({4'h0, codeB}, 16'h0123);
    chkWord(loadsB[15:0], 16'h0001);
    rstn = 1'b0;
    repeat (8) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (6) @(negedge clk_sys);
    chkWord({4'h0, codeB}, 16'h0000);
    chkWord(loadsB[15:0], 16'h0001);
    chkFlag(outValid, 1'b1);
    chkFlag(reqReady, 1'b1);
    complete_run();
  end
endmodule
